// [act_conversion_timing.sv]
// How it works
// RULE1 - sample and conversion phases run on a prescaled enable whose period is never under 33.3 ns.
// RULE2 - after a start event at least two cpu clocks pass before sampling begins.
// RULE3 - the sample window lasts between 2 and 32 prescaled periods.
// RULE4 - the window length comes from the sample-window prescaler field of control register one.
// RULE5 - conversion lasts at least ten prescaled periods after sampling ends.
// RULE6 - the result is loaded no sooner than two cpu clocks after conversion ends.
// RULE7 - the interrupt request rises at least two cpu clocks after the conversion flag is set.
// RULE8 - one conversion is start delay plus window plus conversion plus load delay.
// RULE9 - sample/hold plus conversion time is never below 500 ns under any setting.
// RULE10 - the external start pin changes the internal signal only after holding a level 6 or 12 edges.
// RULE11 - bit 6 of system control register two picks 12 edges when set and 6 when clear.
// RULE12 - the trigger source holds the pin at a new level for its cycles argument plus one cycle.
// RULE13 - a start during a conversion is held pending and starts once the result is loaded; the code starts it after the interrupt delay, from idle.
`include "act_map.svh"

module act_conversion_timing
    import act_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic event_start,
    input wire logic external_convert_start_pin,
    input wire logic [15:0] system_control_status_two,
    input wire logic [4:0] sample_window_prescaler,
    input wire logic [9:0] converter_data,
    input wire logic flag_clear,
    output act_phase_t phase,
    output act_result_t result,
    output logic adc_clk_enable
);
    localparam int DIV = `ACT_ADC_DIV;
    localparam int SHC_MIN = `ACT_SHC_MIN_CYC;

    act_state_t state;
    logic qual_level;
    logic qual_prev;
    logic pending;
    logic start_now;
    logic [3:0] div_count;
    logic adc_tick;
    logic [5:0] adc_count;
    logic [5:0] sample_len;
    logic [1:0] cpu_count;
    logic [9:0] shc_count;
    logic [9:0] captured;

    act_qualifier u_qual (
        .clk(clk),
        .reset(reset),
        .pin_async(external_convert_start_pin),
        .long_sel(system_control_status_two[`ACT_QUAL_SEL_BIT]), // RULE11
        .level(qual_level)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            qual_prev <= 1'b0;
        end else begin
            qual_prev <= qual_level;
        end
    end

    // prescaled adc clock as a one-cycle enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_count <= 4'h0;
            adc_tick <= 1'b0;
        end else if (div_count == 4'(DIV - 1)) begin
            div_count <= 4'h0;
            adc_tick <= 1'b1; // RULE1
        end else begin
            div_count <= div_count + 4'h1;
            adc_tick <= 1'b0;
        end
    end

    assign adc_clk_enable = adc_tick;

    // field value plus one, clamped to the legal window
    always_comb begin
        sample_len = {1'b0, sample_window_prescaler} + 6'h01; // RULE4
        if (sample_len < 6'(`ACT_SH_MIN)) begin
            sample_len = 6'(`ACT_SH_MIN); // RULE3
        end
    end

    // a trigger that arrives while busy is remembered; several while busy merge into one start
    assign start_now = event_start || (qual_level && !qual_prev);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending <= 1'b0;
        end else if (start_now) begin
            pending <= 1'b1; // RULE13
        end else if (state == ACT_IDLE) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ACT_IDLE;
            cpu_count <= 2'h0;
            adc_count <= 6'h00;
        end else begin
            case (state)
                ACT_IDLE: begin
                    cpu_count <= 2'h0;
                    if (pending) begin
                        state <= ACT_SOC_WAIT; // RULE13
                    end
                end
                ACT_SOC_WAIT: begin
                    cpu_count <= cpu_count + 2'h1;
                    // wait for an adc edge so the window is whole periods
                    if (cpu_count >= 2'(`ACT_SOC_DELAY - 1) && adc_tick) begin
                        state <= ACT_SAMPLE; // RULE2
                        adc_count <= 6'h00;
                    end else if (cpu_count >= 2'(`ACT_SOC_DELAY - 1)) begin
                        cpu_count <= cpu_count;
                    end
                end
                ACT_SAMPLE: begin
                    if (adc_tick) begin
                        if (adc_count + 6'h01 >= sample_len) begin
                            state <= ACT_CONVERT; // RULE3
                            adc_count <= 6'h00;
                        end else begin
                            adc_count <= adc_count + 6'h01;
                        end
                    end
                end
                ACT_CONVERT: begin
                    if (adc_tick) begin
                        // also stretch until the sample-plus-convert total is met
                        if (adc_count + 6'h01 >= 6'(`ACT_CONV_MIN)
                                && shc_count >= 10'(SHC_MIN)) begin
                            state <= ACT_LOAD_WAIT; // RULE5 RULE9
                            cpu_count <= 2'h0;
                        end else if (adc_count < 6'h3f) begin
                            adc_count <= adc_count + 6'h01;
                        end
                    end
                end
                ACT_LOAD_WAIT: begin
                    cpu_count <= cpu_count + 2'h1;
                    if (cpu_count == 2'(`ACT_EOC_DELAY - 1)) begin
                        state <= ACT_INT_WAIT; // RULE6 RULE8
                        cpu_count <= 2'h0;
                    end
                end
                ACT_INT_WAIT: begin
                    cpu_count <= cpu_count + 2'h1;
                    if (cpu_count == 2'(`ACT_INT_DELAY - 1)) begin
                        state <= ACT_IDLE; // RULE7
                    end
                end
                default: begin
                    state <= ACT_IDLE;
                end
            endcase
        end
    end

    // cpu cycles spent sampling and converting, saturating
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shc_count <= 10'h000;
        end else if (state == ACT_SAMPLE || state == ACT_CONVERT) begin
            if (shc_count != 10'h3ff) begin
                shc_count <= shc_count + 10'h001; // RULE9
            end
        end else begin
            shc_count <= 10'h000;
        end
    end

    // converter output captured at the end of conversion, published after the load delay
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            captured <= 10'h000;
        end else if (state == ACT_CONVERT && adc_tick) begin
            captured <= converter_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= '0;
        end else begin
            phase.busy <= state != ACT_IDLE;
            phase.sampling <= state == ACT_SAMPLE;
            phase.converting <= state == ACT_CONVERT;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result.value <= 10'h000;
        end else if (state == ACT_LOAD_WAIT && cpu_count == 2'(`ACT_EOC_DELAY - 1)) begin
            result.value <= captured; // RULE6
        end
    end

    // set wins over clear; irq follows the flag after the delay
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result.flag <= 1'b0;
            result.irq <= 1'b0;
        end else begin
            if (state == ACT_LOAD_WAIT && cpu_count == 2'(`ACT_EOC_DELAY - 1)) begin
                result.flag <= 1'b1;
            end else if (flag_clear) begin
                result.flag <= 1'b0;
            end
            if (state == ACT_INT_WAIT && cpu_count == 2'(`ACT_INT_DELAY - 1)) begin
                result.irq <= 1'b1; // RULE7
            end else if (flag_clear) begin
                result.irq <= 1'b0;
            end
        end
    end
endmodule : act_conversion_timing

// [act_conversion_timing_checker.sv]
module act_conversion_timing_checker
    import act_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] sample_window_prescaler,
    input wire act_phase_t phase,
    input wire act_result_t result,
    input wire logic adc_clk_enable
);
    logic [8:0] smp_cnt;
    logic [8:0] cnv_cnt;
    logic [9:0] tot_cnt;
    logic [8:0] win_cyc;
    // a zero field still gives the two-period minimum window
    assign win_cyc = (sample_window_prescaler == 5'h00) ? 9'h00e
        : 9'(7 * sample_window_prescaler + 7);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            smp_cnt <= 9'h000;
            cnv_cnt <= 9'h000;
            tot_cnt <= 10'h000;
        end else begin
            smp_cnt <= phase.sampling ? smp_cnt + 9'h001 : 9'h000;
            cnv_cnt <= phase.converting ? cnv_cnt + 9'h001 : 9'h000;
            if (!phase.busy) begin
                tot_cnt <= 10'h000;
            end else if (phase.sampling || phase.converting) begin
                tot_cnt <= tot_cnt + 10'h001;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_ADC_TICK: assert property (adc_clk_enable |=> !adc_clk_enable [*6] ##1 adc_clk_enable)
        else $error("adc tick spacing wrong");
    AST_SOC_DELAY: assert property ($rose(phase.busy) |-> !phase.sampling [*2])
        else $error("sampling began too soon");
    AST_SH_MIN: assert property ($rose(phase.sampling) |-> phase.sampling [*8])
        else $error("sample window too short");
    AST_SH_MAX: assert property (smp_cnt <= 9'h0e0)
        else $error("sample window too long");
    AST_SH_LEN: assert property ($fell(phase.sampling) |-> smp_cnt == win_cyc)
        else $error("sample window length wrong");
    AST_CONV_MIN: assert property ($fell(phase.converting) |-> cnv_cnt >= 9'h046)
        else $error("conversion too short");
    AST_SHC_MIN: assert property ($fell(phase.converting) |-> tot_cnt >= 10'h064)
        else $error("sample plus conversion too short");
    AST_LOAD: assert property ($rose(result.flag) |-> !phase.converting && !$past(phase.converting) && !phase.sampling)
        else $error("result loaded during conversion");
    AST_INT: assert property ($rose(result.flag) |-> !result.irq [*2] ##1 result.irq)
        else $error("interrupt timing wrong");
    AST_SEQ: assert property ($rose(phase.busy) |-> ##[100:340] $rose(result.flag))
        else $error("conversion did not complete in time");
    cover property ($fell(phase.sampling) && sample_window_prescaler == 5'h1f);
    cover property ($rose(result.irq));
    cover property ($rose(phase.busy) && result.flag);
endmodule : act_conversion_timing_checker

bind act_conversion_timing act_conversion_timing_checker u_act_conversion_timing_checker (
    .clk(clk),
    .reset(reset),
    .sample_window_prescaler(sample_window_prescaler),
    .phase(phase),
    .result(result),
    .adc_clk_enable(adc_clk_enable)
);

// [act_conversion_timing_tb_top.sv]
module act_conversion_timing_tb_top
    import act_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset;
    logic event_start;
    logic start_pin;
    logic [15:0] system_control_status_two;
    logic [4:0] sample_window_prescaler;
    logic [9:0] converter_data;
    logic flag_clear;
    act_phase_t phase;
    act_result_t result;
    logic adc_clk_enable;
    int fail_count = 0;
    int n_tests = 0;
    int n;
    act_conversion_timing u_act_conversion_timing (
        .clk(clk),
        .reset(reset),
        .event_start(event_start),
        .external_convert_start_pin(start_pin),
        .system_control_status_two(system_control_status_two),
        .sample_window_prescaler(sample_window_prescaler),
        .converter_data(converter_data),
        .flag_clear(flag_clear),
        .phase(phase),
        .result(result),
        .adc_clk_enable(adc_clk_enable)
    );
    act_trigger_src u_act_trigger_src (
        .clk(clk),
        .event_start(event_start),
        .start_pin(start_pin)
    );
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic wait_flag(output int cnt);
        cnt = 0;
        while (result.flag !== 1'b1 && cnt < 600) begin
            @(negedge clk);
            cnt++;
        end
        chk(16'(cnt < 600), 16'h0001);
    endtask : wait_flag
    task automatic clear_flag();
        @(negedge clk) flag_clear = 1'b1;
        @(negedge clk) flag_clear = 1'b0;
    endtask : clear_flag
    task automatic s_event(input logic [4:0] p, input logic [9:0] d);
        @(negedge clk);
        sample_window_prescaler = p;
        converter_data = d;
        u_act_trigger_src.pulse_event();
        wait_flag(n);
        chk(16'(n >= 103), 16'h0001);
        chk(16'(result.value), 16'(d));
        repeat (3) @(negedge clk);
        chk(16'(result.irq), 16'h0001);
        clear_flag();
        chk({14'h0000, result.flag, result.irq}, 16'h0000);
    endtask : s_event
    task automatic s_pin(input logic lng);
        int qual;
        qual = lng ? 12 : 6;
        @(negedge clk) system_control_status_two = {9'h000, lng, 6'h00};
        // glitch one cycle shorter than the qualifier
        u_act_trigger_src.hold_pin(1'b1, qual - 2);
        u_act_trigger_src.hold_pin(1'b0, 30);
        chk(16'(phase.busy), 16'h0000);
        u_act_trigger_src.hold_pin(1'b1, qual + 2);
        wait_flag(n);
        u_act_trigger_src.hold_pin(1'b0, qual + 2);
        clear_flag();
    endtask : s_pin
    task automatic s_pending();
        u_act_trigger_src.pulse_event();
        repeat (20) @(negedge clk);
        u_act_trigger_src.pulse_event();
        u_act_trigger_src.pulse_event();
        wait_flag(n);
        // let the interrupt rise first, or its set beats the clear and it sticks
        repeat (3) @(negedge clk);
        chk(16'(result.irq), 16'h0001);
        clear_flag();
        wait_flag(n);
        repeat (3) @(negedge clk);
        chk(16'(result.irq), 16'h0001);
        clear_flag();
        repeat (400) @(negedge clk);
        chk({14'h0000, result.flag, result.irq}, 16'h0000);
    endtask : s_pending
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    initial begin
        reset = 1'b1;
        system_control_status_two = 16'h0000;
        sample_window_prescaler = 5'h00;
        converter_data = 10'h000;
        flag_clear = 1'b0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        chk({1'b0, phase, result}, 16'h0000);
        s_event(5'h00, 10'h2a5);
        s_event(5'h01, 10'h15a);
        s_event(5'h1f, 10'h3ff);
        s_pin(1'b0);
        s_pin(1'b1);
        s_pending();
        close_out();
    end
endmodule : act_conversion_timing_tb_top

// [act_map.svh]
`ifndef ACT_MAP_SVH
`define ACT_MAP_SVH

// clock rate and documented times
`define ACT_CLK_PERIOD_PS 5000
`define ACT_ADC_MIN_PERIOD_PS 33300
`define ACT_SHC_MIN_PS 500000
// prescaled clock: least divide that keeps the period at or above the minimum (round up)
`define ACT_ADC_DIV ((`ACT_ADC_MIN_PERIOD_PS + `ACT_CLK_PERIOD_PS - 1) / `ACT_CLK_PERIOD_PS)
// fixed cpu-clock delays
`define ACT_SOC_DELAY 2
`define ACT_EOC_DELAY 2
`define ACT_INT_DELAY 2
// sample window bounds and conversion length, in adc clock periods
`define ACT_SH_MIN 2
`define ACT_SH_MAX 32
`define ACT_CONV_MIN 10
// total of sample window and conversion must reach this, in cpu cycles
`define ACT_SHC_MIN_CYC ((`ACT_SHC_MIN_PS + `ACT_CLK_PERIOD_PS - 1) / `ACT_CLK_PERIOD_PS)
// qualifier lengths
`define ACT_QUAL_SHORT 6
`define ACT_QUAL_LONG 12
`define ACT_QUAL_SEL_BIT 6

`endif

// [act_pkg.sv]
package act_pkg;
    typedef enum logic [2:0] {
        ACT_IDLE,
        ACT_SOC_WAIT,
        ACT_SAMPLE,
        ACT_CONVERT,
        ACT_LOAD_WAIT,
        ACT_INT_WAIT
    } act_state_t;

    typedef struct packed {
        logic busy;
        logic sampling;
        logic converting;
    } act_phase_t;

    typedef struct packed {
        logic [9:0] value;
        logic flag;
        logic irq;
    } act_result_t;
endpackage : act_pkg

// [act_qualifier.sv]
`include "act_map.svh"

// passes a level only after it has been steady for the selected number of edges
module act_qualifier
    import act_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic pin_async,
    input wire logic long_sel,
    output logic level
);
    logic sync_a;
    logic sync_b;
    logic [3:0] stable_count;
    logic [3:0] need;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_async;
            sync_b <= sync_a;
        end
    end

    assign need = long_sel ? 4'(`ACT_QUAL_LONG) : 4'(`ACT_QUAL_SHORT); // RULE11

    // counts edges at a level different from the output; any bounce restarts it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stable_count <= 4'h0;
            level <= 1'b0;
        end else if (sync_b == level) begin
            stable_count <= 4'h0;
        end else if (stable_count + 4'h1 >= need) begin
            level <= sync_b; // RULE10
            stable_count <= 4'h0;
        end else begin
            stable_count <= stable_count + 4'h1;
        end
    end
endmodule : act_qualifier

// [act_trigger_src.sv]
module act_trigger_src (
    input wire logic clk,
    output logic event_start,
    output logic start_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        event_start = 1'b0;
        start_pin = 1'b0;
    end
    task automatic pulse_event();
        @(negedge clk) event_start = 1'b1;
        @(negedge clk) event_start = 1'b0;
    endtask : pulse_event
    // level stands cycles+1 periods; shorter than the qualifier only for glitch tests
    task automatic hold_pin(input logic lvl, input int cycles);
        @(negedge clk) start_pin = lvl;
        repeat (cycles) @(negedge clk);
    endtask : hold_pin
endmodule : act_trigger_src
